// ===== fspc_top.sv
// Purpose: Sequencer behind the boot-ROM call entry points for flash self-programming
// Assumes: Flash and RAM ports answer with a one-cycle done/valid pulse
// Notes: Arguments are loaded over AXI4-Lite; writing the call register is the call
//
// Behaviour
// - Command chosen by boot call entry argument
// - 0x17 erases page at loaded address
// - 0x1A mass erase needs accumulator key 0x55
// - After mass erase enter serial ISP mode
// - 0x11 reads flash byte into read register
// - 0x26 block read, count 0 to 255
// - Block read copies flash to RAM at X
// - 0x14 programs write register byte at address
// - 0x23 block write, count 0 to 16
// - Block write takes RAM bytes from X
// - 0x62 exit resets the whole device
// - 0x00 enters serial ISP until serial exit
// - Call needs key loaded within 6 cycles
// - Interrupts blocked during routine, enable unchanged
//
// Implementation choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
module fspc_top (
  // System
  input wire logic clk_sys,
  input wire logic sys_rst,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Flash array port
  output fspc_pkg::fspc_flash_req_t flash_req_ff,
  input wire logic flash_done,
  input wire logic [7:0] flash_rdata,
  // RAM port
  output fspc_pkg::fspc_ram_req_t ram_req_ff,
  input wire logic ram_done,
  input wire logic [7:0] ram_rdata,
  // Core side
  output logic irq_block_ff,
  output logic call_return_ff,
  output logic device_reset_req_ff,
  output logic serial_isp_mode_ff,
  input wire logic serial_exit
);
  // ==========================================================
  // Sequencer states
  typedef enum logic [2:0] {S_IDLE, S_FLASH, S_RAM, S_DONE, S_SERIAL} fspc_state_t;
  fspc_state_t state_ff;
  // Argument registers
  logic [7:0] flash_addr_high_ff, flash_addr_low_ff, read_data_reg_ff, write_data_reg_ff;
  logic [7:0] transfer_count_reg_ff, call_key_reg_ff, write_timing_reg_ff, index_x_ff;
  logic [7:0] accum_ff;
  // Key age counter; saturates so a stale key cannot validate a call
  logic [3:0] key_age_ff;
  logic reject_ff;
  // Working copies during a block transfer
  logic [15:0] cur_addr_ff;
  logic [7:0] cur_ram_ff, remain_ff;
  logic [7:0] cmd_ff;
  logic [7:0] hold_ff;
  // Bus handshake holding
  logic aw_got_ff, w_got_ff;
  logic [7:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic wr_fire, call_fire, key_ok;
  logic [7:0] call_entry;

  // Decode a register byte address into a known/unknown flag
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a <= fspc_pkg::OFS_STATUS) && (a[1:0] == 2'b00);
  endfunction

  // ==========================================================
  // AXI write channel: address and data taken in either order
  assign wr_fire = aw_got_ff && w_got_ff && !s_axi_bvalid;
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      aw_addr_ff <= fspc_pkg::RST_BYTE;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= fspc_pkg::RESP_OKAY;
    end
    else
    begin
      // Ready pulses one cycle when idle; single outstanding write
      s_axi_awready <= !aw_got_ff && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_got_ff && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(aw_addr_ff) ? fspc_pkg::RESP_OKAY : fspc_pkg::RESP_SLVERR;
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Call decode: a write to the call register with lane 0 is the call
  assign call_entry = w_data_ff[7:0];
  assign call_fire = wr_fire && (aw_addr_ff == fspc_pkg::OFS_CALL) && w_strb_ff[0];
  assign key_ok = (call_key_reg_ff == fspc_pkg::CALL_KEY_VALUE)
                  && (key_age_ff <= fspc_pkg::KEY_WINDOW_CYC);

  // Argument registers written by software
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      flash_addr_high_ff <= fspc_pkg::RST_BYTE;
      flash_addr_low_ff <= fspc_pkg::RST_BYTE;
      write_data_reg_ff <= fspc_pkg::RST_BYTE;
      transfer_count_reg_ff <= fspc_pkg::RST_BYTE;
      call_key_reg_ff <= fspc_pkg::RST_BYTE;
      write_timing_reg_ff <= fspc_pkg::RST_BYTE;
      index_x_ff <= fspc_pkg::RST_BYTE;
      accum_ff <= fspc_pkg::RST_BYTE;
    end
    else if (wr_fire && w_strb_ff[0])
    begin
      // Address bytes are split as the caller loads them
      case (aw_addr_ff)
        fspc_pkg::OFS_ADDR_HIGH: flash_addr_high_ff <= w_data_ff[7:0];
        fspc_pkg::OFS_ADDR_LOW: flash_addr_low_ff <= w_data_ff[7:0];
        fspc_pkg::OFS_WRITE_DATA: write_data_reg_ff <= w_data_ff[7:0];
        fspc_pkg::OFS_COUNT: transfer_count_reg_ff <= w_data_ff[7:0];
        fspc_pkg::OFS_KEY: call_key_reg_ff <= w_data_ff[7:0];
        fspc_pkg::OFS_TIMING: write_timing_reg_ff <= w_data_ff[7:0];
        fspc_pkg::OFS_INDEX_X: index_x_ff <= w_data_ff[7:0];
        fspc_pkg::OFS_ACCUM: accum_ff <= w_data_ff[7:0];
        default: ;
      endcase
    end
  end

  // Key age: cleared on key load, saturates past the window
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      key_age_ff <= 4'hF;
    else if (wr_fire && w_strb_ff[0] && aw_addr_ff == fspc_pkg::OFS_KEY)
      key_age_ff <= 4'h0;
    else if (call_fire)
      key_age_ff <= 4'hF; // A key validates one call only
    else if (key_age_ff != 4'hF)
      key_age_ff <= key_age_ff + 4'h1;
  end

  // ==========================================================
  // AXI read channel
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= fspc_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= is_mapped(s_axi_araddr) ? fspc_pkg::RESP_OKAY : fspc_pkg::RESP_SLVERR;
        case (s_axi_araddr)
          fspc_pkg::OFS_ADDR_HIGH: s_axi_rdata <= {24'h00_0000, flash_addr_high_ff};
          fspc_pkg::OFS_ADDR_LOW: s_axi_rdata <= {24'h00_0000, flash_addr_low_ff};
          fspc_pkg::OFS_READ_DATA: s_axi_rdata <= {24'h00_0000, read_data_reg_ff};
          fspc_pkg::OFS_WRITE_DATA: s_axi_rdata <= {24'h00_0000, write_data_reg_ff};
          fspc_pkg::OFS_COUNT: s_axi_rdata <= {24'h00_0000, transfer_count_reg_ff};
          fspc_pkg::OFS_KEY: s_axi_rdata <= {24'h00_0000, call_key_reg_ff};
          fspc_pkg::OFS_TIMING: s_axi_rdata <= {24'h00_0000, write_timing_reg_ff};
          fspc_pkg::OFS_INDEX_X: s_axi_rdata <= {24'h00_0000, index_x_ff};
          fspc_pkg::OFS_ACCUM: s_axi_rdata <= {24'h00_0000, accum_ff};
          fspc_pkg::OFS_STATUS: s_axi_rdata <= {28'h000_0000, irq_block_ff,
              serial_isp_mode_ff, reject_ff, state_ff != S_IDLE};
          default: s_axi_rdata <= 32'h0000_0000;
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Sequencer: one routine at a time; calls while busy are refused
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_ff <= S_IDLE;
      flash_req_ff <= '0;
      ram_req_ff <= '0;
      read_data_reg_ff <= fspc_pkg::RST_BYTE;
      cur_addr_ff <= 16'h0000;
      cur_ram_ff <= fspc_pkg::RST_BYTE;
      remain_ff <= fspc_pkg::RST_BYTE;
      cmd_ff <= fspc_pkg::RST_BYTE;
      hold_ff <= fspc_pkg::RST_BYTE;
      reject_ff <= 1'b0;
      irq_block_ff <= 1'b0;
      call_return_ff <= 1'b0;
      device_reset_req_ff <= 1'b0;
      serial_isp_mode_ff <= 1'b0;
    end
    else
    begin
      call_return_ff <= 1'b0;
      flash_req_ff.req <= 1'b0;
      ram_req_ff.req <= 1'b0;
      case (state_ff)
        S_IDLE:
        begin
          if (call_fire)
          begin
            cmd_ff <= call_entry;
            cur_addr_ff <= {flash_addr_high_ff, flash_addr_low_ff};
            cur_ram_ff <= index_x_ff;
            remain_ff <= transfer_count_reg_ff;
            reject_ff <= 1'b0;
            if (!key_ok)
              reject_ff <= 1'b1;
            else
            begin
              irq_block_ff <= 1'b1;
              case (call_entry)
                fspc_pkg::ENT_PAGE_ERASE:
                begin
                  flash_req_ff <= '{1'b1, fspc_pkg::FOP_PAGE_ERASE,
                      {flash_addr_high_ff, flash_addr_low_ff}, 8'h00};
                  state_ff <= S_FLASH;
                end
                fspc_pkg::ENT_MASS_ERASE:
                begin
                  if (accum_ff == fspc_pkg::MASS_CONFIRM_KEY)
                  begin
                    flash_req_ff <= '{1'b1, fspc_pkg::FOP_MASS_ERASE, 16'h0000, 8'h00};
                    state_ff <= S_FLASH;
                  end
                  else
                    state_ff <= S_DONE;
                end
                fspc_pkg::ENT_READ_BYTE:
                begin
                  flash_req_ff <= '{1'b1, fspc_pkg::FOP_READ,
                      {flash_addr_high_ff, flash_addr_low_ff}, 8'h00};
                  state_ff <= S_FLASH;
                end
                fspc_pkg::ENT_WRITE_BYTE:
                begin
                  flash_req_ff <= '{1'b1, fspc_pkg::FOP_PROG,
                      {flash_addr_high_ff, flash_addr_low_ff}, write_data_reg_ff};
                  state_ff <= S_FLASH;
                end
                fspc_pkg::ENT_BLOCK_READ, fspc_pkg::ENT_BLOCK_WRITE:
                begin
                  // A count of zero finishes at once; write count above 16 refused
                  if (call_entry == fspc_pkg::ENT_BLOCK_WRITE
                      && transfer_count_reg_ff > fspc_pkg::BLOCK_WRITE_MAX)
                  begin
                    reject_ff <= 1'b1;
                    state_ff <= S_DONE;
                  end
                  else if (transfer_count_reg_ff == 8'h00)
                    state_ff <= S_DONE;
                  else if (call_entry == fspc_pkg::ENT_BLOCK_READ)
                  begin
                    flash_req_ff <= '{1'b1, fspc_pkg::FOP_READ,
                        {flash_addr_high_ff, flash_addr_low_ff}, 8'h00};
                    state_ff <= S_FLASH;
                  end
                  else
                  begin
                    ram_req_ff <= '{1'b1, 1'b0, index_x_ff, 8'h00};
                    state_ff <= S_RAM;
                  end
                end
                fspc_pkg::ENT_EXIT: device_reset_req_ff <= 1'b1;
                fspc_pkg::ENT_SERIAL_ISP:
                begin
                  serial_isp_mode_ff <= 1'b1;
                  state_ff <= S_SERIAL;
                end
                default:
                begin
                  reject_ff <= 1'b1;
                  state_ff <= S_DONE;
                end
              endcase
            end
          end
        end
        S_FLASH:
        begin
          // Wait for the array to finish before any next step
          if (flash_done)
          begin
            case (cmd_ff)
              fspc_pkg::ENT_READ_BYTE:
              begin
                read_data_reg_ff <= flash_rdata;
                state_ff <= S_DONE;
              end
              fspc_pkg::ENT_MASS_ERASE:
              begin
                serial_isp_mode_ff <= 1'b1;
                state_ff <= S_SERIAL;
              end
              fspc_pkg::ENT_BLOCK_READ:
              begin
                ram_req_ff <= '{1'b1, 1'b1, cur_ram_ff, flash_rdata};
                state_ff <= S_RAM;
              end
              fspc_pkg::ENT_BLOCK_WRITE:
              begin
                remain_ff <= remain_ff - 8'h01;
                cur_addr_ff <= cur_addr_ff + 16'h0001;
                cur_ram_ff <= cur_ram_ff + 8'h01;
                if (remain_ff == 8'h01)
                  state_ff <= S_DONE;
                else
                begin
                  ram_req_ff <= '{1'b1, 1'b0, cur_ram_ff + 8'h01, 8'h00};
                  state_ff <= S_RAM;
                end
              end
              default: state_ff <= S_DONE;
            endcase
          end
        end
        S_RAM:
        begin
          if (ram_done)
          begin
            if (cmd_ff == fspc_pkg::ENT_BLOCK_WRITE)
            begin
              hold_ff <= ram_rdata;
              flash_req_ff <= '{1'b1, fspc_pkg::FOP_PROG, cur_addr_ff, ram_rdata};
              state_ff <= S_FLASH;
            end
            else
            begin
              remain_ff <= remain_ff - 8'h01;
              cur_addr_ff <= cur_addr_ff + 16'h0001;
              cur_ram_ff <= cur_ram_ff + 8'h01;
              if (remain_ff == 8'h01)
                state_ff <= S_DONE;
              else
              begin
                flash_req_ff <= '{1'b1, fspc_pkg::FOP_READ, cur_addr_ff + 16'h0001, 8'h00};
                state_ff <= S_FLASH;
              end
            end
          end
        end
        S_DONE:
        begin
          // Return only once all flash work is over; enable state untouched
          call_return_ff <= 1'b1;
          irq_block_ff <= 1'b0;
          state_ff <= S_IDLE;
        end
        S_SERIAL:
        begin
          if (serial_exit)
            device_reset_req_ff <= 1'b1;
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Checks
  rej_nokey_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_ff == S_IDLE && call_fire && !key_ok) |=> reject_ff && state_ff == S_IDLE)
    else $error("call without fresh key was accepted");
  undef_noop_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_ff == S_IDLE && call_fire && key_ok && call_entry == 8'h55)
    |=> !flash_req_ff.req && !ram_req_ff.req)
    else $error("undefined entry started an operation");
  irq_busy_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_ff == S_FLASH || state_ff == S_RAM) |-> irq_block_ff)
    else $error("interrupts not blocked while routine runs");
  ret_done_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    call_return_ff |-> $past(state_ff) == S_DONE && !irq_block_ff)
    else $error("return without completion");
  mass_key_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (flash_req_ff.req && flash_req_ff.op == fspc_pkg::FOP_MASS_ERASE)
    |-> $past(accum_ff) == fspc_pkg::MASS_CONFIRM_KEY)
    else $error("mass erase without confirmation key");
  mass_serial_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_ff == S_FLASH && flash_done && cmd_ff == fspc_pkg::ENT_MASS_ERASE)
    |=> serial_isp_mode_ff && !call_return_ff)
    else $error("mass erase did not enter serial mode");
  exit_reset_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_ff == S_IDLE && call_fire && key_ok && call_entry == fspc_pkg::ENT_EXIT)
    |=> device_reset_req_ff)
    else $error("exit did not request reset");
  blkw_limit_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_ff == S_IDLE && call_fire && key_ok && call_entry == fspc_pkg::ENT_BLOCK_WRITE
     && transfer_count_reg_ff > fspc_pkg::BLOCK_WRITE_MAX) |=> ##[0:1] call_return_ff)
    else $error("oversize block write not refused");
  read_cap_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_ff == S_FLASH && flash_done && cmd_ff == fspc_pkg::ENT_READ_BYTE)
    |=> read_data_reg_ff == $past(flash_rdata))
    else $error("read byte not captured");
  cov_blkr_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
    ram_req_ff.req && ram_req_ff.we);
  cov_blkw_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
    flash_req_ff.req && cmd_ff == fspc_pkg::ENT_BLOCK_WRITE);
  cov_serial_c: cover property (@(posedge clk_sys) disable iff (sys_rst) serial_isp_mode_ff);
endmodule

// ===== fspc_pkg.sv
// Purpose: Shared constants and types for the flash self-program call sequencer
// Assumes: 100 MHz core clock, byte-wide flash and RAM ports
// Notes: Register offsets are word-aligned byte addresses on the AXI4-Lite slave
package fspc_pkg;
  // ==========================================================
  // Entry points
  localparam logic [7:0] ENT_PAGE_ERASE = 8'h17;
  localparam logic [7:0] ENT_MASS_ERASE = 8'h1A;
  localparam logic [7:0] ENT_READ_BYTE = 8'h11;
  localparam logic [7:0] ENT_BLOCK_READ = 8'h26;
  localparam logic [7:0] ENT_WRITE_BYTE = 8'h14;
  localparam logic [7:0] ENT_BLOCK_WRITE = 8'h23;
  localparam logic [7:0] ENT_EXIT = 8'h62;
  localparam logic [7:0] ENT_SERIAL_ISP = 8'h00;
  // ==========================================================
  // Keys and limits
  localparam logic [7:0] MASS_CONFIRM_KEY = 8'h55;
  localparam logic [7:0] CALL_KEY_VALUE = 8'h98;
  localparam logic [3:0] KEY_WINDOW_CYC = 4'h6;
  localparam logic [7:0] BLOCK_WRITE_MAX = 8'h10;
  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_ADDR_HIGH = 8'h00;
  localparam logic [7:0] OFS_ADDR_LOW = 8'h04;
  localparam logic [7:0] OFS_READ_DATA = 8'h08;
  localparam logic [7:0] OFS_WRITE_DATA = 8'h0C;
  localparam logic [7:0] OFS_COUNT = 8'h10;
  localparam logic [7:0] OFS_KEY = 8'h14;
  localparam logic [7:0] OFS_TIMING = 8'h18;
  localparam logic [7:0] OFS_INDEX_X = 8'h1C;
  localparam logic [7:0] OFS_ACCUM = 8'h20;
  localparam logic [7:0] OFS_CALL = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h28;
  // Status field positions
  localparam int ST_BUSY = 0;
  localparam int ST_REJECT = 1;
  localparam int ST_SERIAL = 2;
  localparam int ST_IRQ_BLOCK = 3;
  // Reset value and AXI response codes
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Flash operation commands on the array port
  typedef enum logic [2:0] {FOP_NONE, FOP_READ, FOP_PROG, FOP_PAGE_ERASE, FOP_MASS_ERASE}
    fspc_fop_t;
  // Flash array request bundle
  typedef struct packed {
    logic req;
    fspc_fop_t op;
    logic [15:0] addr;
    logic [7:0] wdata;
  } fspc_flash_req_t;
  // RAM request bundle
  typedef struct packed {
    logic req;
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fspc_ram_req_t;
endpackage

// ===== fspc_mem_model.sv
// Purpose: Flash array and RAM responder behind the self-program sequencer
// Assumes: Only the low address byte selects a cell in this small model
// Notes: Read lines carry changing garbage outside their done cycle
`timescale 1ns/10ps
module fspc_mem_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Flash side
  input wire fspc_pkg::fspc_flash_req_t flash_req,
  output logic flash_done,
  output logic [7:0] flash_rdata,
  // RAM side
  input wire fspc_pkg::fspc_ram_req_t ram_req,
  output logic ram_done,
  output logic [7:0] ram_rdata
);
  // ==========================================================
  // Storage and operation log
  logic [7:0] fmem [0:255]; // Flash cells
  logic [7:0] rmem [0:255]; // RAM cells
  int fops = 0; // Flash requests seen, never reset
  fspc_pkg::fspc_flash_req_t fq; // Last flash request
  fspc_pkg::fspc_ram_req_t rq; // Last RAM request
  logic [1:0] fwait_ff; // Flash busy countdown
  logic rwait_ff; // RAM busy flag
  initial flash_rdata = 8'h5A;
  initial ram_rdata = 8'hA5;
  // ==========================================================
  // Flash answers late so that early sampling by the design shows up
  always @(posedge clk_sys or posedge sys_rst)
  begin
    flash_done <= 1'b0;
    flash_rdata <= ~flash_rdata;
    if (sys_rst)
      fwait_ff <= 2'h0;
    else if (flash_req.req)
    begin
      fq <= flash_req;
      fwait_ff <= 2'h2;
      fops <= fops + 1;
    end
    else if (fwait_ff == 2'h1)
    begin
      flash_done <= 1'b1;
      fwait_ff <= 2'h0;
      if (fq.op == fspc_pkg::FOP_READ)
        flash_rdata <= fmem[fq.addr[7:0]];
      if (fq.op == fspc_pkg::FOP_PROG)
        fmem[fq.addr[7:0]] <= fq.wdata;
      if (fq.op == fspc_pkg::FOP_MASS_ERASE)
        for (int i = 0; i < 256; i++)
          fmem[i] <= 8'hFF;
    end
    else if (fwait_ff != 2'h0)
      fwait_ff <= fwait_ff - 2'h1;
  end
  // ==========================================================
  // RAM answers one cycle after its request
  always @(posedge clk_sys or posedge sys_rst)
  begin
    ram_done <= 1'b0;
    ram_rdata <= ~ram_rdata;
    if (sys_rst)
      rwait_ff <= 1'b0;
    else if (ram_req.req)
    begin
      rq <= ram_req;
      rwait_ff <= 1'b1;
    end
    else if (rwait_ff)
    begin
      ram_done <= 1'b1;
      rwait_ff <= 1'b0;
      if (rq.we)
        rmem[rq.addr] <= rq.wdata;
      else
        ram_rdata <= rmem[rq.addr];
    end
  end
endmodule

// ===== testbench.sv
// Purpose: Self-checking bench for the flash self-program call sequencer
// Assumes: Bus answers are sampled mid-cycle, drives land at rising edges
// Notes: Each call except the stale-key one loads the key just before writing the call register
`timescale 1ns/10ps
module testbench;
  // ==========================================================
  // Signals
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic serial_exit = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, flash_done, ram_done;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, d;
  logic [7:0] flash_rdata, ram_rdata;
  logic irq_block, call_ret, dev_rst_req, isp_mode;
  fspc_pkg::fspc_flash_req_t flash_req;
  fspc_pkg::fspc_ram_req_t ram_req;
  int num_errors = 0, cmp_count = 0, cycles = 0, f0;
  fspc_top i_fspc_top (.clk_sys(clk_sys), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .flash_req_ff(flash_req), .flash_done(flash_done), .flash_rdata(flash_rdata),
    .ram_req_ff(ram_req), .ram_done(ram_done), .ram_rdata(ram_rdata),
    .irq_block_ff(irq_block), .call_return_ff(call_ret), .device_reset_req_ff(dev_rst_req),
    .serial_isp_mode_ff(isp_mode), .serial_exit(serial_exit));
  fspc_mem_model i_fspc_mem_model (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .flash_req(flash_req), .flash_done(flash_done), .flash_rdata(flash_rdata),
    .ram_req(ram_req), .ram_done(ram_done), .ram_rdata(ram_rdata));
  // ==========================================================
  // Clock and hang guard, sized well above the longest sequence
  initial forever #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      num_errors = num_errors + 1;
      finish_test();
    end
  end
  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp)
    begin
      num_errors = num_errors + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Address and data raised together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic ha, hw, hb;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= {24'h00_0000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(negedge clk_sys);
      ha = awready;
      hw = wready;
      hb = bvalid;
      @(posedge clk_sys);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end
    while (hb !== 1'b1);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    logic ha, hr;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(negedge clk_sys);
      ha = arready;
      hr = rvalid;
      v = rdata;
      @(posedge clk_sys);
      if (ha) arvalid <= 1'b0;
    end
    while (hr !== 1'b1);
    rready <= 1'b0;
  endtask
  // Key then call; bounded wait for the return pulse
  task automatic call(input logic [7:0] entry);
    wr(fspc_pkg::OFS_KEY, fspc_pkg::CALL_KEY_VALUE);
    wr(fspc_pkg::OFS_CALL, entry);
    for (int n = 0; n < 300 && call_ret !== 1'b1; n++)
      @(negedge clk_sys);
    @(posedge clk_sys);
  endtask
  task automatic addr(input logic [7:0] hi, input logic [7:0] lo);
    wr(fspc_pkg::OFS_ADDR_HIGH, hi);
    wr(fspc_pkg::OFS_ADDR_LOW, lo);
    f0 = i_fspc_mem_model.fops;
  endtask
  task automatic reset_dut();
    sys_rst <= 1'b1;
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  initial
  begin
    for (int i = 0; i < 16; i++)
      i_fspc_mem_model.rmem[8'h80 + i] = 8'(8'h20 + i);
    i_fspc_mem_model.fmem[8'h35] = 8'hA7;
    reset_dut();
    wr(fspc_pkg::OFS_TIMING, 8'h12);
    addr(8'h00, 8'h35);
    call(fspc_pkg::ENT_READ_BYTE);
    rd(fspc_pkg::OFS_READ_DATA, d);
    check(d, 32'h0000_00A7);
    wr(fspc_pkg::OFS_WRITE_DATA, 8'h3C);
    addr(8'h00, 8'h40);
    call(fspc_pkg::ENT_WRITE_BYTE);
    check(i_fspc_mem_model.fmem[8'h40], 32'h0000_003C);
    // Sixteen bytes from an aligned start stay in one 64-byte span
    addr(8'h00, 8'h00);
    wr(fspc_pkg::OFS_COUNT, 8'h10);
    wr(fspc_pkg::OFS_INDEX_X, 8'h80);
    call(fspc_pkg::ENT_BLOCK_WRITE);
    for (int i = 0; i < 16; i++)
      check(i_fspc_mem_model.fmem[i], 32'(8'h20 + i));
    wr(fspc_pkg::OFS_COUNT, 8'h03);
    wr(fspc_pkg::OFS_INDEX_X, 8'hC0);
    call(fspc_pkg::ENT_BLOCK_READ);
    for (int i = 0; i < 4; i++)
      check(i_fspc_mem_model.rmem[8'hC0 + i], i < 3 ? 32'(8'h20 + i) : 32'h0000_00xx);
    addr(8'h01, 8'h00);
    call(fspc_pkg::ENT_PAGE_ERASE);
    check({i_fspc_mem_model.fq.op, i_fspc_mem_model.fq.addr}, {3'h3, 16'h0100});
    // Refused calls: too long a block, unknown entry, stale key
    addr(8'h00, 8'h00);
    wr(fspc_pkg::OFS_COUNT, 8'h11);
    call(fspc_pkg::ENT_BLOCK_WRITE);
    call(8'h55);
    wr(fspc_pkg::OFS_KEY, fspc_pkg::CALL_KEY_VALUE);
    repeat (10) @(posedge clk_sys);
    wr(fspc_pkg::OFS_CALL, fspc_pkg::ENT_READ_BYTE);
    rd(fspc_pkg::OFS_STATUS, d);
    check(d[fspc_pkg::ST_REJECT], 1'b1);
    check(i_fspc_mem_model.fops - f0, 0);
    wr(fspc_pkg::OFS_ACCUM, 8'h54);
    call(fspc_pkg::ENT_MASS_ERASE);
    wr(fspc_pkg::OFS_ACCUM, fspc_pkg::MASS_CONFIRM_KEY);
    call(fspc_pkg::ENT_MASS_ERASE);
    check(i_fspc_mem_model.fmem[8'h40], 32'h0000_00FF);
    check({isp_mode, 31'(i_fspc_mem_model.fops - f0)}, {1'b1, 31'h1});
    reset_dut();
    call(fspc_pkg::ENT_EXIT);
    check({dev_rst_req, isp_mode}, 2'h2);
    reset_dut();
    call(fspc_pkg::ENT_SERIAL_ISP);
    check({dev_rst_req, isp_mode}, 2'h1);
    serial_exit <= 1'b1;
    repeat (5) @(posedge clk_sys);
    check(dev_rst_req, 1'b1);
    finish_test();
  end
endmodule
